/* File: rtl/operator_panel_status.sv */
`timescale 1ns/1ps
// Behaviour
// - at boot start, boot-phase lamp dark and init lamp lit during ROM diagnostic
// - init diagnostic success turns boot-phase lamp on and init lamp off
// - firmware loading blinks boot-phase lamp 200 ms on, 200 ms off
// - once running, boot-phase lamp blinks 400 ms on, 400 ms off
// - an error freezes the boot-phase lamp at its current level
// - power lamp lit only while all three supply-good inputs are high or the lamp test is held
// - init switch restarts the same boot sequence as power-on
// - init lamp lit while booting begins
// - init switch ignored unless lock switch is in enable position
// - holding fault switch lights every panel lamp as lamp test
// - fault lamp lit whenever a fault is recorded and no code is being shown
// - each fault switch press-release with a fault queued shows a blinking 5-bit code, with none queued it ends the display
// - code bit4 init, bit3 fault, bit2 online, bits1..0 unlabelled lamps
// - hardware codes 01,02,03,11,12,13,15 for the failing units
// - other codes 16,18,19,1A for files, requestors, early reboot, inconsistency
// - fatal fault halts operation until reset, power-on or init switch
// - nonfatal faults queue and show one per press-release, oldest first
// - unlabelled lamps are dark except for the low code bits and the lamp test
// - in secure position only the fault switch acts

module operator_panel_status #(
  parameter int unsigned TICK_CYCLES     = opanel_pkg::MS_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = opanel_pkg::DEBOUNCE_CYC,
  parameter int unsigned QUEUE_DEPTH     = opanel_pkg::QUEUE_DEPTH
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // register bus
  input  wire opanel_pkg::apb_req_t apbReq,
  output opanel_pkg::apb_rsp_t      apbRsp,
  // panel switches, high when pressed or in enable position
  input  wire logic                 initSwitch,
  input  wire logic                 faultSwitch,
  input  wire logic                 lockEnable,
  // supplies: three dc rails, good when high
  input  wire logic [2:0]           supplyGood,
  // subsystem side
  input  wire logic                 onlineActive,
  output logic                      rebootReq,
  output logic                      subsysRun,
  // panel lamps
  output opanel_pkg::lamps_t        lamps
);

  localparam int unsigned TW = $clog2(TICK_CYCLES);
  localparam int unsigned QW = $clog2(QUEUE_DEPTH + 1);
  localparam int unsigned MW = opanel_pkg::MS_W;

  initial
  begin
    if (TICK_CYCLES < 2)
      $error("tick count must be at least two");
    if (QUEUE_DEPTH < 1 || QUEUE_DEPTH > 255)
      $error("queue depth must be 1 to 255");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0]                  pwrSync1;
    logic [2:0]                  pwrSync2;
    opanel_pkg::phase_t          phase;
    logic                        stateLevel;
    logic [TW-1:0]               tickCnt;
    logic [MW-1:0]               bootMs;
    logic [MW-1:0]               codeMs;
    logic                        codeOn;
    logic                        fatal;
    logic                        overflow;
    logic [QUEUE_DEPTH-1:0][4:0] queue;
    logic [QW-1:0]               count;
    logic                        showing;
    logic [4:0]                  showCode;
    logic [31:0]                 rdata;
    logic                        rebootReq;
    opanel_pkg::lamps_t          lamps;
  } state_t;

  state_t st;
  state_t next_st;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic halfDone(input logic [MW-1:0] ms, input int unsigned half);
    halfDone = (ms == MW'(half - 1));
  endfunction : halfDone

  function automatic logic [4:0] cleanCode(input logic [4:0] code);
    unique case (code)
      opanel_pkg::FC_PORT_PROC,
      opanel_pkg::FC_DISK_CHAN,
      opanel_pkg::FC_TAPE_CHAN,
      opanel_pkg::FC_CTRL_PROC,
      opanel_pkg::FC_MEMORY,
      opanel_pkg::FC_BOOT_TAPE,
      opanel_pkg::FC_PORT_LINK,
      opanel_pkg::FC_NO_FILES,
      opanel_pkg::FC_NO_REQ,
      opanel_pkg::FC_EARLY_BOOT,
      opanel_pkg::FC_SW_INCONS: cleanCode = code;
      // an unlisted code is shown as an inconsistency, never as garbage
      default:                  cleanCode = opanel_pkg::FC_SW_INCONS;
    endcase
  endfunction : cleanCode

  // ------------------------------------------------------------
  // switches
  // ------------------------------------------------------------
  logic initLevel;
  logic initRelease;
  logic faultLevel;
  logic faultRelease;
  logic lockLevel;

  switch_debounce #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_init_sw (
    .clk      (clk),
    .resetn   (resetn),
    .rawPin   (initSwitch),
    .level    (initLevel),
    .released (initRelease)
  );

  switch_debounce #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_fault_sw (
    .clk      (clk),
    .resetn   (resetn),
    .rawPin   (faultSwitch),
    .level    (faultLevel),
    .released (faultRelease)
  );

  switch_debounce #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_lock_sw (
    .clk      (clk),
    .resetn   (resetn),
    .rawPin   (lockEnable),
    .level    (lockLevel),
    .released ()
  );

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic       setup;
  logic       wrEn;
  logic       mapped;
  logic [7:0] wrOfs;
  logic       restart;
  logic       diagOk;
  logic       loadGo;
  logic       loadEnd;
  logic       seqErr;
  logic       post;
  logic [4:0] postCode;
  logic       postFatal;
  logic       pop;
  logic       msTick;

  assign setup   = apbReq.psel && !apbReq.penable;
  assign wrEn    = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign wrOfs   = apbReq.paddr;
  assign mapped  = (apbReq.paddr == opanel_pkg::CTRL_OFS)
                || (apbReq.paddr == opanel_pkg::POST_OFS)
                || (apbReq.paddr == opanel_pkg::STATUS_OFS)
                || (apbReq.paddr == opanel_pkg::CODE_OFS);

  assign diagOk    = wrEn && wrOfs == opanel_pkg::CTRL_OFS
                     && apbReq.pwdata[opanel_pkg::CTRL_DIAG_OK_BIT];
  assign loadGo    = wrEn && wrOfs == opanel_pkg::CTRL_OFS
                     && apbReq.pwdata[opanel_pkg::CTRL_LOAD_GO_BIT];
  assign loadEnd   = wrEn && wrOfs == opanel_pkg::CTRL_OFS
                     && apbReq.pwdata[opanel_pkg::CTRL_LOAD_END_BIT];
  assign seqErr    = wrEn && wrOfs == opanel_pkg::CTRL_OFS
                     && apbReq.pwdata[opanel_pkg::CTRL_SEQ_ERR_BIT];
  assign postCode  = apbReq.pwdata[opanel_pkg::POST_CODE_LSB +: 5];
  assign postFatal = apbReq.pwdata[opanel_pkg::POST_FATAL_BIT];
  // a zero code names no fault and is dropped
  assign post      = wrEn && wrOfs == opanel_pkg::POST_OFS && postCode != 5'h00;

  assign restart = initRelease && lockLevel;
  assign pop     = faultRelease;
  assign msTick  = (st.tickCnt == TW'(TICK_CYCLES - 1));

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_st           = st;
    next_st.pwrSync1  = supplyGood;
    next_st.pwrSync2  = st.pwrSync1;
    next_st.rebootReq = 1'b0;
    next_st.tickCnt   = msTick ? '0 : st.tickCnt + TW'(1);

    // boot-phase lamp sequencing
    unique case (st.phase)
      opanel_pkg::PH_ROM_DIAG:
      begin
        next_st.stateLevel = 1'b0;
        if (diagOk)
        begin
          next_st.phase      = opanel_pkg::PH_DIAG_OK;
          next_st.stateLevel = 1'b1;
        end
      end
      opanel_pkg::PH_DIAG_OK:
      begin
        if (loadGo)
        begin
          next_st.phase  = opanel_pkg::PH_LOADING;
          next_st.bootMs = '0;
        end
      end
      opanel_pkg::PH_LOADING:
      begin
        if (msTick)
        begin
          next_st.bootMs = st.bootMs + MW'(1);
          if (halfDone(st.bootMs, opanel_pkg::FAST_HALF_MS))
          begin
            next_st.bootMs     = '0;
            next_st.stateLevel = !st.stateLevel;
          end
        end
        if (loadEnd)
        begin
          next_st.phase  = opanel_pkg::PH_RUNNING;
          next_st.bootMs = '0;
        end
      end
      opanel_pkg::PH_RUNNING:
      begin
        if (msTick)
        begin
          next_st.bootMs = st.bootMs + MW'(1);
          if (halfDone(st.bootMs, opanel_pkg::SLOW_HALF_MS))
          begin
            next_st.bootMs     = '0;
            next_st.stateLevel = !st.stateLevel;
          end
        end
      end
      opanel_pkg::PH_FROZEN:
      begin
        next_st.stateLevel = st.stateLevel;
      end
      default:
      begin
        next_st.phase = opanel_pkg::PH_FROZEN;
      end
    endcase

    // an error freezes the lamp at the level it had in this cycle
    if (seqErr && st.phase != opanel_pkg::PH_FROZEN)
    begin
      next_st.phase      = opanel_pkg::PH_FROZEN;
      next_st.stateLevel = st.stateLevel;
    end

    // code display blink, fixed half period
    if (st.showing && msTick)
    begin
      next_st.codeMs = st.codeMs + MW'(1);
      if (halfDone(st.codeMs, opanel_pkg::CODE_HALF_MS))
      begin
        next_st.codeMs = '0;
        next_st.codeOn = !st.codeOn;
      end
    end

    // fault queue: pop oldest at slot 0, push behind the survivors
    if (pop)
    begin
      if (st.count != '0)
      begin
        next_st.showing  = 1'b1;
        next_st.showCode = st.queue[0];
        next_st.codeMs   = '0;
        next_st.codeOn   = 1'b1;
        for (int i = 0; i < int'(QUEUE_DEPTH) - 1; i++)
          next_st.queue[i] = st.queue[i+1];
        next_st.count = st.count - QW'(1);
      end
      else
        next_st.showing = 1'b0;
    end
    if (post)
    begin
      if (postFatal)
      begin
        next_st.fatal = 1'b1;
        next_st.phase = opanel_pkg::PH_FROZEN;
        next_st.stateLevel = st.stateLevel;
      end
      // a fatal code is queued too so the operator can read it
      if (next_st.count == QW'(QUEUE_DEPTH))
        next_st.overflow = 1'b1;
      else
      begin
        next_st.queue[next_st.count] = cleanCode(postCode);
        next_st.count = next_st.count + QW'(1);
      end
    end

    // init switch: same path as power-on, clears faults and display
    if (restart)
    begin
      next_st.phase      = opanel_pkg::PH_ROM_DIAG;
      next_st.stateLevel = 1'b0;
      next_st.bootMs     = '0;
      next_st.fatal      = 1'b0;
      next_st.overflow   = 1'b0;
      next_st.count      = '0;
      next_st.showing    = 1'b0;
      next_st.rebootReq  = 1'b1;
    end

    // register read data captured in the setup cycle
    if (setup)
    begin
      unique case (apbReq.paddr)
        opanel_pkg::STATUS_OFS:
        begin
          next_st.rdata = '0;
          next_st.rdata[opanel_pkg::ST_PHASE_LSB +: 3] = st.phase;
          next_st.rdata[opanel_pkg::ST_LEVEL_BIT]      = st.stateLevel;
          next_st.rdata[opanel_pkg::ST_FATAL_BIT]      = st.fatal;
          next_st.rdata[opanel_pkg::ST_SHOW_BIT]       = st.showing;
          next_st.rdata[opanel_pkg::ST_OVF_BIT]        = st.overflow;
          next_st.rdata[opanel_pkg::ST_ENABLE_BIT]     = lockLevel;
          next_st.rdata[opanel_pkg::ST_COUNT_LSB +: 8] = 8'(st.count);
          next_st.rdata[opanel_pkg::ST_CODE_LSB +: 5]  = st.queue[0];
        end
        opanel_pkg::CODE_OFS: next_st.rdata = {27'h0000000, st.showCode};
        default:              next_st.rdata = '0;
      endcase
    end

    // lamp outputs
    next_st.lamps.power     = &st.pwrSync2;
    next_st.lamps.bootPhase = next_st.stateLevel;
    next_st.lamps.init      = (next_st.phase == opanel_pkg::PH_ROM_DIAG);
    next_st.lamps.fault     = next_st.fatal || next_st.count != '0;
    next_st.lamps.online    = onlineActive;
    next_st.lamps.low1      = 1'b0;
    next_st.lamps.low0      = 1'b0;
    if (next_st.showing)
    begin
      next_st.lamps.init   = next_st.codeOn && next_st.showCode[4];
      next_st.lamps.fault  = next_st.codeOn && next_st.showCode[3];
      next_st.lamps.online = next_st.codeOn && next_st.showCode[2];
      next_st.lamps.low1   = next_st.codeOn && next_st.showCode[1];
      next_st.lamps.low0   = next_st.codeOn && next_st.showCode[0];
    end
    if (faultLevel)
      next_st.lamps = '1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st           <= '0;
      st.phase     <= opanel_pkg::PH_ROM_DIAG;
      st.lamps     <= '0;
      st.lamps.init <= 1'b1;
    end
    else
      st <= next_st;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign apbRsp.prdata  = st.rdata;
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !mapped;
  assign rebootReq      = st.rebootReq;
  // fatal or frozen sequence stops normal operation
  assign subsysRun      = (st.phase == opanel_pkg::PH_RUNNING) && !st.fatal;
  assign lamps          = st.lamps;

endmodule : operator_panel_status

/* File: rtl/opanel_pkg.sv */
package opanel_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000;
  localparam int unsigned FAST_HALF_MS  = 200;
  localparam int unsigned SLOW_HALF_MS  = 400;
  localparam int unsigned CODE_HALF_MS  = 250;
  localparam int unsigned DEBOUNCE_MS   = 10;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * MS_CYCLES;
  localparam int unsigned MS_W          = 9;
  localparam int unsigned QUEUE_DEPTH   = 8;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] POST_OFS   = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] CODE_OFS   = 8'h0c;

  // sequence control, write one to pulse
  localparam int unsigned CTRL_DIAG_OK_BIT  = 0;
  localparam int unsigned CTRL_LOAD_GO_BIT  = 1;
  localparam int unsigned CTRL_LOAD_END_BIT = 2;
  localparam int unsigned CTRL_SEQ_ERR_BIT  = 3;

  // fault post fields
  localparam int unsigned POST_CODE_LSB  = 0;
  localparam int unsigned POST_FATAL_BIT = 8;

  // status fields
  localparam int unsigned ST_PHASE_LSB  = 0;
  localparam int unsigned ST_LEVEL_BIT  = 3;
  localparam int unsigned ST_FATAL_BIT  = 4;
  localparam int unsigned ST_SHOW_BIT   = 5;
  localparam int unsigned ST_OVF_BIT    = 6;
  localparam int unsigned ST_ENABLE_BIT = 7;
  localparam int unsigned ST_COUNT_LSB  = 8;
  localparam int unsigned ST_CODE_LSB   = 16;

  // ------------------------------------------------------------
  // fault codes
  // ------------------------------------------------------------
  localparam logic [4:0] FC_PORT_PROC  = 5'h01;
  localparam logic [4:0] FC_DISK_CHAN  = 5'h02;
  localparam logic [4:0] FC_TAPE_CHAN  = 5'h03;
  localparam logic [4:0] FC_CTRL_PROC  = 5'h11;
  localparam logic [4:0] FC_MEMORY     = 5'h12;
  localparam logic [4:0] FC_BOOT_TAPE  = 5'h13;
  localparam logic [4:0] FC_PORT_LINK  = 5'h15;
  localparam logic [4:0] FC_NO_FILES   = 5'h16;
  localparam logic [4:0] FC_NO_REQ     = 5'h18;
  localparam logic [4:0] FC_EARLY_BOOT = 5'h19;
  localparam logic [4:0] FC_SW_INCONS  = 5'h1a;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_ROM_DIAG = 3'b000,
    PH_DIAG_OK  = 3'b001,
    PH_LOADING  = 3'b010,
    PH_RUNNING  = 3'b011,
    PH_FROZEN   = 3'b100
  } phase_t;

  typedef struct packed {
    logic power;
    logic bootPhase;
    logic init;
    logic fault;
    logic online;
    logic low1;
    logic low0;
  } lamps_t;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage : opanel_pkg

/* File: rtl/switch_debounce.sv */
`timescale 1ns/1ps

module switch_debounce #(
  parameter int unsigned DEBOUNCE_CYCLES = opanel_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // raw contact, high when pressed
  input  wire logic rawPin,
  // clean outputs
  output logic      level,
  output logic      released
);

  localparam int unsigned CW = $clog2(DEBOUNCE_CYCLES + 1);

  initial
  begin
    if (DEBOUNCE_CYCLES < 1)
      $error("debounce count must be at least one");
  end

  typedef struct packed {
    logic          sync1;
    logic          sync2;
    logic          level;
    logic          released;
    logic [CW-1:0] cnt;
  } deb_t;

  deb_t st;
  deb_t next_st;

  // ------------------------------------------------------------
  // filter
  // ------------------------------------------------------------
  always_comb
  begin
    next_st          = st;
    next_st.sync1    = rawPin;
    next_st.sync2    = st.sync1;
    next_st.released = 1'b0;
    // a new level must hold for the whole window, bounce restarts it
    if (st.sync2 == st.level)
      next_st.cnt = '0;
    else if (st.cnt == CW'(DEBOUNCE_CYCLES - 1))
    begin
      next_st.cnt      = '0;
      next_st.level    = st.sync2;
      next_st.released = st.level;
    end
    else
      next_st.cnt = st.cnt + CW'(1);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign level    = st.level;
  assign released = st.released;

endmodule : switch_debounce

/* File: sim/panel_operator.sv */
`timescale 1ns/1ps
module panel_operator (
  // clock
  input  wire logic clk,
  // contacts, high when pressed or in enable position
  output logic      initSwitch,
  output logic      faultSwitch,
  output logic      lockEnable
);
  // ------------------------------------------------------------
  // operator hand
  // ------------------------------------------------------------
  initial
  begin
    initSwitch = 1'b0;
    faultSwitch = 1'b0;
    lockEnable = 1'b0;
  end

  // contacts chatter on make and on break, so one press is never a clean edge
  task automatic press(input logic isFault, input int hold);
    int i;
    logic v;
    for (i = 0; i < hold + 12; i++)
    begin
      @(posedge clk);
      v = (i < hold) ? 1'b1 : 1'b0;
      if (i < 3 || (i >= hold && i < hold + 3))
        v = i[0];
      if (isFault)
        faultSwitch <= v;
      else
        initSwitch <= v;
    end
  endtask : press

  task automatic setLock(input logic v);
    @(posedge clk);
    lockEnable <= v;
  endtask : setLock
endmodule : panel_operator

/* File: sim/operator_panel_chk.sv */
`timescale 1ns/1ps
module operator_panel_chk #(
  parameter int unsigned TICK_CYCLES     = 4,
  parameter int unsigned DEBOUNCE_CYCLES = 3,
  parameter int unsigned QUEUE_DEPTH     = 8
) (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 resetn,
  // register bus
  input wire opanel_pkg::apb_req_t apbReq,
  input wire opanel_pkg::apb_rsp_t apbRsp,
  // switches and supplies
  input wire logic                 initSwitch,
  input wire logic                 faultSwitch,
  input wire logic                 lockEnable,
  input wire logic [2:0]           supplyGood,
  // subsystem and lamps
  input wire logic                 onlineActive,
  input wire logic                 rebootReq,
  input wire logic                 subsysRun,
  input wire opanel_pkg::lamps_t   lamps
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic access;
  logic mapped;
  assign access = apbReq.psel && apbReq.penable;
  assign mapped = apbReq.paddr inside {8'h00, 8'h04, 8'h08, 8'h0c};

  sequence s_access;
    access;
  endsequence
  // debounce plus sync must be covered by eight steady samples
  sequence s_held;
    faultSwitch [*8];
  endsequence

  a_reset_lamps: assert property (disable iff (1'b0) !resetn |-> lamps == 7'h10
    && !rebootReq && !subsysRun) else $error("lamps wrong in reset");
  a_ready_now: assert property (s_access |-> apbRsp.pready)
    else $error("no ready in access");
  a_slverr_map: assert property (s_access |-> apbRsp.pslverr == !mapped)
    else $error("slave error wrong");
  a_rd_unmapped: assert property (s_access ##0 (!mapped && !apbReq.pwrite)
    |-> apbRsp.prdata == 32'h0) else $error("unmapped read not zero");
  a_rd_hold: assert property (s_access |=> $stable(apbRsp.prdata))
    else $error("read data moved");
  a_reboot_once: assert property (rebootReq |=> !rebootReq)
    else $error("reboot pulse too long");
  a_reboot_lock: assert property (rebootReq |-> $past(lockEnable, 6))
    else $error("reboot while secure");
  a_reboot_boot: assert property (rebootReq |-> ##[0:2]
    (lamps.init && !lamps.bootPhase && !subsysRun)) else $error("reboot lamps");
  a_lamp_test: assert property (s_held |-> ##2 lamps == 7'h7f)
    else $error("lamp test not all lit");
  a_power_off: assert property (!(&supplyGood) [*5] |-> !lamps.power || lamps == 7'h7f)
    else $error("power lamp lit on bad rail");
  a_power_on: assert property ((&supplyGood) [*5] |-> lamps.power)
    else $error("power lamp dark");
  c_reboot: cover property (rebootReq);
endmodule : operator_panel_chk

bind operator_panel_status operator_panel_chk #(
  .TICK_CYCLES(TICK_CYCLES),
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
  .QUEUE_DEPTH(QUEUE_DEPTH)
) operator_panel_chk_inst (.clk(clk), .resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp),
  .initSwitch(initSwitch), .faultSwitch(faultSwitch), .lockEnable(lockEnable),
  .supplyGood(supplyGood), .onlineActive(onlineActive), .rebootReq(rebootReq),
  .subsysRun(subsysRun), .lamps(lamps));

/* File: sim/operator_panel_status_logic_bench.sv */
`timescale 1ns/1ps
module operator_panel_status_logic_bench;
  localparam int unsigned TICK = 4;
  localparam int unsigned QD   = 8;
  logic                 clk = 1'b0;
  logic                 resetn = 1'b1;
  opanel_pkg::apb_req_t req;
  opanel_pkg::apb_rsp_t rsp;
  logic                 initSw;
  logic                 faultSw;
  logic                 lockSw;
  logic [2:0]           supply;
  logic                 online;
  logic                 rebootReq;
  logic                 subsysRun;
  opanel_pkg::lamps_t   lamps;
  logic [31:0]          rd;
  logic                 err;
  logic [4:0]           q[$];
  logic [4:0]           legal[11] = '{5'h01, 5'h02, 5'h03, 5'h11, 5'h12, 5'h13, 5'h15,
                                      5'h16, 5'h18, 5'h19, 5'h1a};
  logic [8:0]           posts[14] = '{9'h013, 9'h001, 9'h01a, 9'h000, 9'h002, 9'h011,
                                      9'h01f, 9'h003, 9'h012, 9'h015, 9'h016, 9'h018,
                                      9'h007, 9'h019};
  logic                 ovf = 1'b0;
  logic                 b;
  int                   seed = 29;
  int                   bad_count = 0;
  int                   n_checks = 0;
  int                   reboots = 0;
  int                   n;

  always #5 clk = ~clk;
  always @(posedge clk) if (rebootReq === 1'b1) reboots++;

  operator_panel_status #(.TICK_CYCLES(TICK), .DEBOUNCE_CYCLES(3), .QUEUE_DEPTH(QD))
    operator_panel_status_inst (.clk(clk), .resetn(resetn), .apbReq(req), .apbRsp(rsp),
    .initSwitch(initSw), .faultSwitch(faultSw), .lockEnable(lockSw), .supplyGood(supply),
    .onlineActive(online), .rebootReq(rebootReq), .subsysRun(subsysRun), .lamps(lamps));
  panel_operator panel_operator_inst (.clk(clk), .initSwitch(initSw),
    .faultSwitch(faultSw), .lockEnable(lockSw));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk);
      if (rsp.pready === 1'b1)
        break;
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (k == 50)
    begin
      bad_count++;
      results();
    end
  endtask : apb

  // unlisted codes are stored as the inconsistency code, zero is dropped
  task post(input logic [8:0] v);
    apb(opanel_pkg::POST_OFS, 1'b1, {23'h0, v});
    if (v[4:0] != 5'h00 && q.size() < QD)
      q.push_back((v[4:0] inside {legal}) ? v[4:0] : 5'h1a);
    else if (v[4:0] != 5'h00)
      ovf = 1'b1;
  endtask : post

  task popCheck;
    logic [4:0] want, shown;
    fork
      panel_operator_inst.press(1'b1, 24);
      begin
        repeat (18) @(posedge clk);
        check(lamps, 7'h7f);
      end
    join
    repeat (4) @(posedge clk);
    if (q.size() > 0) shown = q[0];
    want = (q.size() > 0) ? q.pop_front() : 5'h00;
    check(lamps[4:0], want);
    apb(opanel_pkg::CODE_OFS, 1'b0, 32'h0);
    check(rd[4:0], shown);
  endtask : popCheck

  task halfLen;
    b = lamps.bootPhase;
    for (n = 0; n < 4000 && lamps.bootPhase === b; n++) @(posedge clk);
    b = lamps.bootPhase;
    for (n = 0; n < 4000 && lamps.bootPhase === b; n++) @(posedge clk);
    if (n == 4000)
    begin
      bad_count++;
      results();
    end
  endtask : halfLen

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    req = '0;
    supply = 3'b111;
    online = 1'b0;
    #1 resetn = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    check(lamps, 7'h10);
    repeat (6)
    begin
      @(posedge clk);
      n = $random(seed);
      supply <= n[2:0];
      online <= n[3];
      repeat (5) @(posedge clk);
      check({lamps.power, lamps.online, lamps[1:0]}, {&supply, online, 2'b00});
    end
    supply <= 3'b111;
    online <= 1'b0;
    apb(8'h40, 1'b0, 32'h0);
    check({err, rd[30:0]}, {1'b1, 31'h0});
    apb(opanel_pkg::STATUS_OFS, 1'b0, 32'h0);
    check(rd[7:0], 8'h00);
    apb(opanel_pkg::CTRL_OFS, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    check({lamps.bootPhase, lamps.init}, 2'b10);
    apb(opanel_pkg::CTRL_OFS, 1'b1, 32'h2);
    halfLen();
    check(n, 200 * TICK);
    apb(opanel_pkg::CTRL_OFS, 1'b1, 32'h4);
    apb(opanel_pkg::STATUS_OFS, 1'b0, 32'h0);
    check({subsysRun, rd[2:0]}, 4'hb);
    halfLen();
    check(n, 400 * TICK);
    post(posts[0]);
    repeat (2) @(posedge clk);
    check(lamps.fault, 1'b1);
    for (int i = 1; i < 14; i++)
    begin
      post(posts[i]);
      if (i % 3 == 2)
        popCheck();
    end
    apb(opanel_pkg::STATUS_OFS, 1'b0, 32'h0);
    check({rd[6], rd[15:8]}, {ovf, 8'(q.size())});
    popCheck();
    repeat (1000) @(posedge clk);
    check(lamps[4:0], 5'h00);
    repeat (q.size() + 1) popCheck();
    post(9'h112);
    repeat (2) @(posedge clk);
    b = lamps.bootPhase;
    apb(opanel_pkg::STATUS_OFS, 1'b0, 32'h0);
    check({subsysRun, rd[4], rd[2:0]}, 5'h0c);
    repeat (1700) @(posedge clk);
    check(lamps.bootPhase, b);
    panel_operator_inst.press(1'b0, 12);
    repeat (4) @(posedge clk);
    check(reboots, 0);
    panel_operator_inst.setLock(1'b1);
    repeat (10) @(posedge clk);
    panel_operator_inst.press(1'b0, 12);
    repeat (4) @(posedge clk);
    check(reboots, 1);
    check({lamps.bootPhase, lamps.init}, 2'b01);
    q.delete();
    apb(opanel_pkg::STATUS_OFS, 1'b0, 32'h0);
    check({rd[15:8], rd[6], rd[4], rd[2:0]}, 32'h0);
    apb(opanel_pkg::CTRL_OFS, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    check({lamps.bootPhase, lamps.init}, 2'b10);
    results();
  end
endmodule : operator_panel_status_logic_bench
